// ### rtl/scl_cfg.svh
`ifndef SCL_CFG_SVH
`define SCL_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SCL_OFS_CTRL 8'h00
`define SCL_OFS_IRQ_STATUS 8'h04
`define SCL_OFS_IRQ_CLEAR 8'h08
`define SCL_OFS_IRQ_ENABLE 8'h0c

// ----------------------------------------
// control register fields
// ----------------------------------------
`define SCL_BIT_DMA_TEST 12
`define SCL_BIT_ERR_LAST 11
`define SCL_BIT_MIS_EN 10
`define SCL_BIT_CACHE_EN 9
`define SCL_BIT_RESERVED 8
`define SCL_BIT_CACHE_INIT 7
`define SCL_BIT_DMA_SOFT 6
`define SCL_BIT_SYNC_HI 5
`define SCL_BIT_SYNC_LO 4
`define SCL_CTRL_RESET 32'h0000_0000

// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define SCL_IRQ_WIDTH 4
`define SCL_EV_MISALIGNMENT_ABORT_ENABLE 0
`define SCL_EV_CACHE_OFF 1
`define SCL_EV_ERROR 2
`define SCL_EV_LAST 3
`define SCL_IRQ_RESET 4'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define SCL_CACHE_INIT_CYCLES 8'h40
`define SCL_INIT_STEP 8'h01
`define SCL_INIT_LAST 8'h01
`define SCL_CNT_WIDTH 8

`endif

// ### rtl/scl_pkg.sv
package scl_pkg;

    // acknowledge synchroniser codes
    typedef enum logic [1:0] {
        SCL_SYNC_ONE_A = 2'h0,
        SCL_SYNC_ONE_B = 2'h1,
        SCL_SYNC_TWO = 2'h2,
        SCL_SYNC_NONE = 2'h3
    } scl_sync_type;

    // transfer width
    typedef enum logic [1:0] {
        SCL_SIZE_BYTE = 2'h0,
        SCL_SIZE_HALF = 2'h1,
        SCL_SIZE_WORD = 2'h2,
        SCL_SIZE_RSVD = 2'h3
    } scl_size_type;

    typedef struct packed {
        logic dma_test_access;
        logic error_last_config;
        logic misalignment_abort_enable;
        logic cache_enable;
        logic dma_soft_reset;
        logic [1:0] ack_synchroniser_select;
    } scl_ctrl_type;

    typedef struct packed {
        scl_ctrl_type ctrl;
        logic [3:0] irq_status;
        logic [3:0] irq_enable;
        logic [7:0] init_cnt;
        logic cache_init_progress;
        logic [31:0] rdata;
        logic data_abort;
        logic burst_last;
        logic xfer_ack;
        logic irq;
        logic dma_reset;
        logic ctx_ram_access;
        logic cache_on;
    } scl_state_type;

    typedef struct packed {
        logic [1:0] stage1;
        logic [1:0] stage2;
    } scl_sync_state_type;

endpackage

// ### rtl/scl_ack_sync.sv
`timescale 1ns/1ps
`default_nettype none

module scl_ack_sync (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // depth select
    input wire logic [1:0] sync_sel,
    // raw pins
    input wire logic transfer_acknowledge_n,
    input wire logic transfer_error_acknowledge_n,
    // conditioned pins
    output logic ack_n,
    output logic err_n
);

    scl_pkg::scl_sync_state_type st_reg;
    scl_pkg::scl_sync_state_type st_next;

    always_comb
    begin
        st_next = st_reg;
        st_next.stage1 = {transfer_error_acknowledge_n, transfer_acknowledge_n};
        st_next.stage2 = st_reg.stage1;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // depth chosen by the select code
    always_comb
    begin
        case (scl_pkg::scl_sync_type'(sync_sel))
            scl_pkg::SCL_SYNC_TWO:
            begin
                {err_n, ack_n} = st_reg.stage2;
            end
            scl_pkg::SCL_SYNC_NONE:
            begin
                {err_n, ack_n} = {transfer_error_acknowledge_n, transfer_acknowledge_n};
            end
            default:
            begin
                {err_n, ack_n} = st_reg.stage1;
            end
        endcase
    end

endmodule // scl_ack_sync

`default_nettype wire

// ### rtl/scl_align_check.sv
`timescale 1ns/1ps
`default_nettype none

module scl_align_check (
    // transfer
    input wire logic [1:0] addr_low,
    input wire logic [1:0] size,
    // result
    output logic misaligned
);

    function automatic logic is_misaligned(input logic [1:0] a, input logic [1:0] s);
        logic r;
        r = 1'b0;
        case (scl_pkg::scl_size_type'(s))
            scl_pkg::SCL_SIZE_HALF:
            begin
                r = a[0];
            end
            scl_pkg::SCL_SIZE_WORD:
            begin
                r = |a;
            end
            default:
            begin
                r = 1'b0;
            end
        endcase
        return r;
    endfunction

    assign misaligned = is_misaligned(addr_low, size);

endmodule // scl_align_check

`default_nettype wire

// ### rtl/scl_top.sv
// Function
// - test access: hold whole dma subsystem in reset, open context ram to cpu
// - test access off: dma runs, cpu reaches only dma control registers
// - error/last zero: error acknowledge means data abort only
// - error/last one: error with acknowledge marks burst end, alone means abort
// - misalignment enable one: misaligned transfers abort; zero: never
// - misaligned: halfword at odd address, word not word aligned
// - cache works only while cache enable is one
// - cache use while cache disabled gives a data abort
// - cache init field reads one while cache initialisation runs
// - dma soft reset one holds only dma in reset; zero releases
// - sync select: 00/01 one stage, 10 two stages, 11 none
// - two stage setting adds one bus clock of latency
//
// The register addresses and the address-and-strobe port were decided locally.
`include "scl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module scl_top (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,

    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,

    // bus acknowledge pins
    input wire logic transfer_acknowledge_n,
    input wire logic transfer_error_acknowledge_n,

    // transfer seen on the system bus
    input wire logic xfer_valid,
    input wire logic [31:0] xfer_addr,
    input wire logic [1:0] xfer_size,
    input wire logic xfer_cache,

    // transfer outcome
    output logic data_abort,
    output logic burst_last,
    output logic xfer_ack,

    // dma and cache control
    output logic dma_reset,
    output logic dma_ctx_ram_access,
    output logic cache_on,

    // interrupt
    output logic irq
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------

    function automatic logic [31:0] ctrl_to_word(input scl_pkg::scl_ctrl_type c, input logic busy);
        logic [31:0] w;
        w = `SCL_CTRL_RESET;
        w[`SCL_BIT_DMA_TEST] = c.dma_test_access;
        w[`SCL_BIT_ERR_LAST] = c.error_last_config;
        w[`SCL_BIT_MIS_EN] = c.misalignment_abort_enable;
        w[`SCL_BIT_CACHE_EN] = c.cache_enable;
        w[`SCL_BIT_RESERVED] = 1'b0;
        w[`SCL_BIT_CACHE_INIT] = busy;
        w[`SCL_BIT_DMA_SOFT] = c.dma_soft_reset;
        w[`SCL_BIT_SYNC_HI:`SCL_BIT_SYNC_LO] = c.ack_synchroniser_select;
        return w;
    endfunction

    function automatic scl_pkg::scl_ctrl_type word_to_ctrl(input logic [31:0] w);
        scl_pkg::scl_ctrl_type c;
        c.dma_test_access = w[`SCL_BIT_DMA_TEST];
        c.error_last_config = w[`SCL_BIT_ERR_LAST];
        c.misalignment_abort_enable = w[`SCL_BIT_MIS_EN];
        c.cache_enable = w[`SCL_BIT_CACHE_EN];
        c.dma_soft_reset = w[`SCL_BIT_DMA_SOFT];
        c.ack_synchroniser_select = w[`SCL_BIT_SYNC_HI:`SCL_BIT_SYNC_LO];
        return c;
    endfunction

    function automatic logic reg_hit(input logic strobe, input logic [7:0] a, input logic [7:0] ofs);
        return strobe && (a == ofs);
    endfunction

    function automatic logic [31:0] irq_to_word(input logic [`SCL_IRQ_WIDTH-1:0] bits);
        logic [31:0] w;
        w = '0;
        w[`SCL_IRQ_WIDTH-1:0] = bits;
        return w;
    endfunction

    function automatic logic [`SCL_CNT_WIDTH-1:0] count_down(input logic [`SCL_CNT_WIDTH-1:0] cnt);
        return cnt - `SCL_INIT_STEP;
    endfunction

    function automatic logic init_ends(input logic [`SCL_CNT_WIDTH-1:0] cnt);
        return cnt == `SCL_INIT_LAST;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------

    scl_pkg::scl_state_type st_reg;
    scl_pkg::scl_state_type st_next;

    logic ack_n;
    logic err_n;
    logic misaligned;
    logic mis_abort;
    logic cache_abort;
    logic err_abort;
    logic ctrl_wr_hit;
    logic clr_wr_hit;
    logic en_wr_hit;
    logic [31:0] rd_word;
    logic [3:0] events;
    logic abort_now;
    logic last_now;
    logic ack_now;
    logic cache_rise;
    scl_pkg::scl_ctrl_type ctrl_new;

    // ----------------------------------------
    // acknowledge conditioning
    // ----------------------------------------

    scl_ack_sync u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .sync_sel(st_reg.ctrl.ack_synchroniser_select),
        .transfer_acknowledge_n(transfer_acknowledge_n),
        .transfer_error_acknowledge_n(transfer_error_acknowledge_n),
        .ack_n(ack_n),
        .err_n(err_n)
    );

    // ----------------------------------------
    // alignment check
    // ----------------------------------------

    scl_align_check u_align (
        .addr_low(xfer_addr[1:0]),
        .size(xfer_size),
        .misaligned(misaligned)
    );

    // ----------------------------------------
    // register decode
    // ----------------------------------------

    always_comb
    begin
        ctrl_wr_hit = reg_hit(reg_wr, reg_addr, `SCL_OFS_CTRL);
        clr_wr_hit = reg_hit(reg_wr, reg_addr, `SCL_OFS_IRQ_CLEAR);
        en_wr_hit = reg_hit(reg_wr, reg_addr, `SCL_OFS_IRQ_ENABLE);
    end

    // ----------------------------------------
    // abort sources
    // ----------------------------------------

    always_comb
    begin
        // misaligned request
        mis_abort = xfer_valid && misaligned && st_reg.ctrl.misalignment_abort_enable;
        // cache touched while its enable is off
        cache_abort = xfer_valid && xfer_cache && !st_reg.cache_on;
    end

    // ----------------------------------------
    // acknowledge pair decode
    // ----------------------------------------

    // pin levels arrive through the selected synchroniser depth
    always_comb
    begin
        last_now = 1'b0;
        ack_now = 1'b0;
        err_abort = 1'b0;
        if (!err_n)
        begin
            if (st_reg.ctrl.error_last_config && !ack_n)
            begin
                last_now = 1'b1;
                ack_now = 1'b1;
            end
            else
            begin
                // error alone, or error under error-only use
                err_abort = 1'b1;
            end
        end
        else if (!ack_n)
        begin
            ack_now = 1'b1;
        end
    end

    // ----------------------------------------
    // event collection
    // ----------------------------------------

    always_comb
    begin
        events = `SCL_IRQ_RESET;
        events[`SCL_EV_MISALIGNMENT_ABORT_ENABLE] = mis_abort;
        events[`SCL_EV_CACHE_OFF] = cache_abort;
        events[`SCL_EV_ERROR] = err_abort;
        events[`SCL_EV_LAST] = last_now;
        abort_now = mis_abort || cache_abort || err_abort;
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------

    // unmapped and write-only offsets read zero
    always_comb
    begin
        rd_word = '0;
        case (reg_addr)
            `SCL_OFS_CTRL:
            begin
                rd_word = ctrl_to_word(st_reg.ctrl, st_reg.cache_init_progress);
            end
            `SCL_OFS_IRQ_STATUS:
            begin
                rd_word = irq_to_word(st_reg.irq_status);
            end
            `SCL_OFS_IRQ_ENABLE:
            begin
                rd_word = irq_to_word(st_reg.irq_enable);
            end
            default:
            begin
                rd_word = '0;
            end
        endcase
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------

    always_comb
    begin
        st_next = st_reg;
        ctrl_new = word_to_ctrl(reg_wdata);
        cache_rise = 1'b0;

        // control register write, bit eight dropped
        if (ctrl_wr_hit)
        begin
            st_next.ctrl = ctrl_new;
            cache_rise = ctrl_new.cache_enable && !st_reg.ctrl.cache_enable;
        end

        // cache initialisation sequence
        if (!st_next.ctrl.cache_enable)
        begin
            st_next.cache_init_progress = 1'b0;
            st_next.init_cnt = '0;
        end
        else if (cache_rise)
        begin
            st_next.cache_init_progress = 1'b1;
            st_next.init_cnt = `SCL_CACHE_INIT_CYCLES;
        end
        else if (st_reg.cache_init_progress)
        begin
            st_next.init_cnt = count_down(st_reg.init_cnt);
            if (init_ends(st_reg.init_cnt))
            begin
                st_next.cache_init_progress = 1'b0;
            end
        end
        st_next.cache_on = st_next.ctrl.cache_enable;

        // dma control
        st_next.dma_reset = st_next.ctrl.dma_test_access || st_next.ctrl.dma_soft_reset;
        st_next.ctx_ram_access = st_next.ctrl.dma_test_access;

        // transfer outcome pulses
        st_next.data_abort = abort_now;
        st_next.burst_last = last_now;
        st_next.xfer_ack = ack_now;

        // interrupt registers, set wins over clear
        if (en_wr_hit)
        begin
            st_next.irq_enable = reg_wdata[`SCL_IRQ_WIDTH-1:0];
        end
        if (clr_wr_hit)
        begin
            st_next.irq_status = st_reg.irq_status & ~reg_wdata[`SCL_IRQ_WIDTH-1:0];
        end
        st_next.irq_status = st_next.irq_status | events;
        st_next.irq = |(st_next.irq_status & st_next.irq_enable);

        // read data for the following cycle only
        st_next.rdata = '0;
        if (reg_rd)
        begin
            st_next.rdata = rd_word;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------

    assign reg_rdata = st_reg.rdata;
    assign data_abort = st_reg.data_abort;
    assign burst_last = st_reg.burst_last;
    assign xfer_ack = st_reg.xfer_ack;
    assign dma_reset = st_reg.dma_reset;
    assign dma_ctx_ram_access = st_reg.ctx_ram_access;
    assign cache_on = st_reg.cache_on;
    assign irq = st_reg.irq;

endmodule // scl_top

`default_nettype wire

// ### verif/scl_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module scl_top_monitor (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // pins and transfer
    input wire logic transfer_acknowledge_n,
    input wire logic transfer_error_acknowledge_n,
    input wire logic xfer_valid,
    input wire logic xfer_cache,
    // outcome
    input wire logic data_abort,
    input wire logic burst_last,
    input wire logic xfer_ack,
    input wire logic dma_reset,
    input wire logic dma_ctx_ram_access,
    input wire logic cache_on
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    wire ctrl_wr = reg_wr && reg_addr == 8'h00;

    // three cycles of one pin low alone
    sequence ack_held;
        (!transfer_acknowledge_n && transfer_error_acknowledge_n) [*3];
    endsequence
    sequence err_held;
        (transfer_acknowledge_n && !transfer_error_acknowledge_n) [*3];
    endsequence

    a_ack_latency: assert property (ack_held |-> ##1 xfer_ack)
        else $error("acknowledge not passed within three cycles");
    a_err_abort: assert property (err_held |-> ##1 data_abort)
        else $error("error acknowledge gave no abort");
    a_burst_pair: assert property (burst_last |-> xfer_ack)
        else $error("burst end without acknowledge");
    a_ctx_set: assert property (ctrl_wr && reg_wdata[12] |-> ##[1:2] dma_ctx_ram_access)
        else $error("context ram access not opened");
    a_ctx_clear: assert property (ctrl_wr && !reg_wdata[12] |-> ##[1:2] !dma_ctx_ram_access)
        else $error("context ram access not closed");
    a_test_resets: assert property (dma_ctx_ram_access |-> dma_reset)
        else $error("dma runs during test access");
    a_soft_reset: assert property (ctrl_wr && reg_wdata[6] |-> ##[1:2] dma_reset)
        else $error("dma soft reset not applied");
    a_soft_release: assert property (ctrl_wr && reg_wdata[12:6] == 7'h00 |-> ##[1:2] !dma_reset)
        else $error("dma not released");
    a_cache_follow: assert property (ctrl_wr && reg_wdata[9] |-> ##[1:2] cache_on)
        else $error("cache not enabled");
    a_cache_abort: assert property (xfer_valid && xfer_cache && !cache_on |=> data_abort)
        else $error("cache use while off not aborted");
    a_reserved_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h00 |-> !reg_rdata[8])
        else $error("reserved bit reads one");
endmodule // scl_top_monitor

bind scl_top scl_top_monitor mon (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .transfer_acknowledge_n(transfer_acknowledge_n),
    .transfer_error_acknowledge_n(transfer_error_acknowledge_n), .xfer_valid(xfer_valid),
    .xfer_cache(xfer_cache), .data_abort(data_abort), .burst_last(burst_last), .xfer_ack(xfer_ack),
    .dma_reset(dma_reset), .dma_ctx_ram_access(dma_ctx_ram_access), .cache_on(cache_on)
);

`default_nettype wire

// ### verif/scl_bus_peer.sv
`timescale 1ns/1ps
`default_nettype none

module scl_bus_peer (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // command: kind 0 ack, 1 error, 2 both
    input wire logic go,
    input wire logic [1:0] kind,
    input wire logic [1:0] delay,
    // pins, pulled up while idle
    output logic transfer_acknowledge_n,
    output logic transfer_error_acknowledge_n
);
    logic [1:0] wait_reg;
    logic [1:0] hold_reg;
    logic [1:0] kind_reg;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_reg <= 2'h0;
            hold_reg <= 2'h0;
            kind_reg <= 2'h0;
        end
        else if (go)
        begin
            wait_reg <= delay;
            hold_reg <= 2'h3;
            kind_reg <= kind;
        end
        else if (wait_reg != 2'h0)
            wait_reg <= wait_reg - 2'h1;
        else if (hold_reg != 2'h0)
            hold_reg <= hold_reg - 2'h1;
    end

    // pins move only just after bus clock edges
    wire active = wait_reg == 2'h0 && hold_reg != 2'h0;
    assign transfer_acknowledge_n = !(active && kind_reg != 2'h1);
    assign transfer_error_acknowledge_n = !(active && kind_reg != 2'h0);
endmodule // scl_bus_peer

`default_nettype wire

// ### verif/scl_top_test.sv
`timescale 1ns/1ps
`default_nettype none

module scl_top_test;
    logic mclk, rst_n, reg_wr, reg_rd, xfer_valid, xfer_cache, go, ack_n, err_n;
    logic data_abort, burst_last, xfer_ack, dma_reset, dma_ctx, cache_on, irq;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, xfer_addr, rd_val;
    logic [1:0] xfer_size, kind, delay;
    int n_fail, n_tests, n;

    scl_top dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .transfer_acknowledge_n(ack_n),
        .transfer_error_acknowledge_n(err_n), .xfer_valid(xfer_valid), .xfer_addr(xfer_addr),
        .xfer_size(xfer_size), .xfer_cache(xfer_cache), .data_abort(data_abort), .burst_last(burst_last),
        .xfer_ack(xfer_ack), .dma_reset(dma_reset), .dma_ctx_ram_access(dma_ctx), .cache_on(cache_on), .irq(irq));
    scl_bus_peer peer (.mclk(mclk), .rst_n(rst_n), .go(go), .kind(kind), .delay(delay),
        .transfer_acknowledge_n(ack_n), .transfer_error_acknowledge_n(err_n));

    // ----
    // tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
        chk(rd_val, e);
    endtask
    // status check, then clear all
    task automatic ev(input logic [3:0] e);
        repeat (2) @(posedge mclk);
        rchk(8'h04, 32'(e));
        wr(8'h08, 32'h0000_000f);
    endtask
    task automatic xf(input logic [31:0] a, input logic [1:0] s, input logic c);
        @(posedge mclk);
        xfer_valid <= 1'b1;
        xfer_addr <= a;
        xfer_size <= s;
        xfer_cache <= c;
        @(posedge mclk);
        xfer_valid <= 1'b0;
    endtask
    // peer answer; n counts cycles to first outcome
    task automatic pin(input logic [1:0] k, input logic [1:0] d);
        @(posedge mclk);
        go <= 1'b1;
        kind <= k;
        delay <= d;
        @(posedge mclk);
        go <= 1'b0;
        n = 0;
        do
        begin
            @(posedge mclk);
            #1 n++;
        end while (n < 12 && xfer_ack !== 1'b1 && data_abort !== 1'b1);
    endtask
    task automatic stop_test;
        if (n_fail == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----
    // clock and watchdog
    // ----
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        stop_test;
    end

    // ----
    // tests
    // ----
    initial
    begin
        {rst_n, reg_wr, reg_rd, xfer_valid, xfer_cache, go, kind, delay, xfer_size} = '0;
        {reg_addr, reg_wdata, xfer_addr} = '0;
        n_fail = 0;
        n_tests = 0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        rchk(8'h00, 32'h0000_0000);
        rchk(8'h10, 32'h0000_0000);
        wr(8'h04, 32'h0000_000f);
        rchk(8'h04, 32'h0000_0000);
        wr(8'h00, 32'h0000_1000);
        repeat (2) @(posedge mclk);
        chk({dma_reset, dma_ctx}, 2'h3);
        wr(8'h00, 32'h0000_0040);
        repeat (2) @(posedge mclk);
        chk({dma_reset, dma_ctx}, 2'h2);
        wr(8'h00, 32'h0000_0180);
        rchk(8'h00, 32'h0000_0000);
        chk({dma_reset, dma_ctx}, 2'h0);
        for (int s = 0; s < 4; s++)
        begin
            wr(8'h00, 32'(s) << 4);
            pin(2'h0, 2'h0);
            chk(n, (s == 2) ? 3 : (s == 3) ? 1 : 2);
            ev(4'h0);
        end
        wr(8'h00, 32'h0000_0000);
        pin(2'h2, 2'h0);
        chk({burst_last, xfer_ack, data_abort}, 32'h0000_0001);
        ev(4'h4);
        pin(2'h1, 2'h3);
        ev(4'h4);
        wr(8'h00, 32'h0000_0800);
        pin(2'h2, 2'h1);
        chk({burst_last, xfer_ack, data_abort}, 32'h0000_0006);
        ev(4'h8);
        pin(2'h1, 2'h0);
        chk({burst_last, xfer_ack, data_abort}, 32'h0000_0001);
        ev(4'h4);
        for (int e = 0; e < 2; e++)
        begin
            wr(8'h00, 32'(e) << 10);
            for (int i = 0; i < 16; i++)
            begin
                xf(32'h0000_1000 + 32'(i % 4), 2'(i / 4), 1'b0);
                ev(4'(e == 1 && ((i / 4 == 1 && i % 2 == 1) || (i / 4 == 2 && i % 4 != 0))));
            end
        end
        wr(8'h00, 32'h0000_0200);
        rchk(8'h00, 32'h0000_0280);
        repeat (70) @(posedge mclk);
        rchk(8'h00, 32'h0000_0200);
        xf(32'h0000_2000, 2'h2, 1'b1);
        ev(4'h0);
        chk(cache_on, 1'b1);
        wr(8'h00, 32'h0000_0000);
        xf(32'h0000_2000, 2'h2, 1'b1);
        ev(4'h2);
        chk(cache_on, 1'b0);
        wr(8'h0c, 32'h0000_0004);
        rchk(8'h0c, 32'h0000_0004);
        pin(2'h1, 2'h0);
        repeat (3) @(posedge mclk);
        chk(irq, 1'b1);
        wr(8'h0c, 32'h0000_0000);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
        wr(8'h0c, 32'h0000_0004);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b1);
        ev(4'h4);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
        stop_test;
    end
endmodule // scl_top_test

`default_nettype wire
